// >>> design/sequencer_stack_entries_10_12.sv
// Sequencer stack entries seven and ten to twelve with APB access and stepping
`include "seq_stack_params.svh"

module sequencer_stack_entries_10_12
  import seq_stack_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_rvalid,
  input  wire logic        seq_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] other_entry_word,
  output logic      [3:0]  active_entry,
  output logic      [3:0]  converter_a_channel_select,
  output logic      [3:0]  converter_b_channel_select,
  output logic             seq_running
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Register index to {hit, slot} of a held entry
  function automatic logic [2:0] slot_lookup(input logic [5:0] idx);
    logic [2:0] res;
    res = 3'h0;
    unique case (idx)
      `SS_IDX_E7:  res = {1'b1, `SS_SLOT_E7};
      `SS_IDX_E10: res = {1'b1, `SS_SLOT_E10};
      `SS_IDX_E11: res = {1'b1, `SS_SLOT_E11};
      `SS_IDX_E12: res = {1'b1, `SS_SLOT_E12};
      default:     res = 3'h0;
    endcase
    return res;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  entry_t      entry_reg [`SS_SLOTS];
  entry_t      entry_next [`SS_SLOTS];
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [15:0] cmd_rdata_reg;
  logic [15:0] cmd_rdata_next;
  logic        cmd_rvalid_reg;
  logic        cmd_rvalid_next;
  seq_state_t  state_reg;
  seq_state_t  state_next;
  logic        running_reg;
  logic        running_next;
  logic [3:0]  index_reg;
  logic [3:0]  index_next;
  logic [3:0]  chan_a_reg;
  logic [3:0]  chan_a_next;
  logic [3:0]  chan_b_reg;
  logic [3:0]  chan_b_next;
  logic [2:0]  apb_lookup;
  logic [2:0]  cmd_lookup;
  logic [2:0]  act_lookup;
  logic        apb_hit;
  logic        apb_write_fire;
  logic        cmd_hit;
  logic [5:0]  act_reg_index;
  entry_t      active_word;
  logic        advance;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------

  // Word aligned APB decode and command address match
  assign apb_lookup     = slot_lookup(paddr[7:2]);
  assign apb_hit        = apb_lookup[2] && (paddr[1:0] == `SS_BYTE_LANE_OK);
  assign apb_write_fire = psel && penable && pready_reg && pwrite && apb_hit;
  assign cmd_lookup     = slot_lookup(cmd_word[`SS_ADDR_HI:`SS_ADDR_LO]);
  assign cmd_hit        = cmd_valid && cmd_lookup[2];

  // ------------------------------------------------------------
  // Stack entry storage
  // ------------------------------------------------------------

  // APB write wins over a command write in the same cycle
  always_comb
  begin
    entry_next = entry_reg;
    if (apb_write_fire)
      entry_next[apb_lookup[1:0]] = pwdata[15:0];
    else if (cmd_hit && cmd_word[`SS_DIR_BIT])
      entry_next[cmd_lookup[1:0]] = cmd_word;
  end

  // Entry registers with their reset contents
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      entry_reg[`SS_SLOT_E7]  <= `SS_RST_E7;
      entry_reg[`SS_SLOT_E10] <= `SS_RST_E10;
      entry_reg[`SS_SLOT_E11] <= `SS_RST_E11;
      entry_reg[`SS_SLOT_E12] <= `SS_RST_E12;
    end
    else
      entry_reg <= entry_next;
  end

  // ------------------------------------------------------------
  // APB slave, one wait state
  // ------------------------------------------------------------

  // Answer on the second access cycle
  always_comb
  begin
    pready_next  = 1'b0;
    prdata_next  = `SS_ZERO_WORD;
    pslverr_next = 1'b0;
    if (psel && penable && !pready_reg)
    begin
      pready_next  = 1'b1;
      pslverr_next = !apb_hit;
      if (apb_hit && !pwrite)
        prdata_next = {`SS_ZERO_HALF, entry_reg[apb_lookup[1:0]]};
    end
  end

  // APB answer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= `SS_ZERO_WORD;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------
  // Command word port
  // ------------------------------------------------------------

  // Read request returns the addressed entry next cycle
  always_comb
  begin
    cmd_rvalid_next = 1'b0;
    cmd_rdata_next  = cmd_rdata_reg;
    if (cmd_hit && !cmd_word[`SS_DIR_BIT])
    begin
      cmd_rvalid_next = 1'b1;
      cmd_rdata_next  = entry_reg[cmd_lookup[1:0]];
    end
  end

  // Command answer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cmd_rvalid_reg <= 1'b0;
      cmd_rdata_reg  <= `SS_ZERO_HALF;
    end
    else
    begin
      cmd_rvalid_reg <= cmd_rvalid_next;
      cmd_rdata_reg  <= cmd_rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------

  // Contents of the active entry, held here or supplied from outside
  assign act_reg_index = `SS_STACK_BASE + {2'b00, index_reg};
  assign act_lookup    = slot_lookup(act_reg_index);
  assign active_word   = act_lookup[2] ? entry_reg[act_lookup[1:0]] : other_entry_word;
  assign advance       = (state_reg == SEQ_RUN) && conv_done;

  // Index step after each finished conversion
  seq_stack_step u_step (
    .start           (seq_start),
    .advance         (advance),
    .return_to_first (active_word[`SS_RET_BIT]),
    .cur_index       (index_reg),
    .next_index      (index_next)
  );

  // Run state and channel selects of the active entry
  always_comb
  begin
    state_next  = state_reg;
    chan_a_next = active_word[`SS_CHA_HI:`SS_CHA_LO];
    chan_b_next = active_word[`SS_CHB_HI:`SS_CHB_LO];
    unique case (state_reg)
      SEQ_IDLE:
        if (seq_start)
          state_next = SEQ_RUN;
      SEQ_RUN:
        state_next = SEQ_RUN;
    endcase
    running_next = (state_next == SEQ_RUN);                  // Registered run flag
  end

  // Sequencer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg  <= SEQ_IDLE;
      running_reg <= 1'b0;
      index_reg  <= `SS_FIRST_ENTRY;
      chan_a_reg <= 4'h0;
      chan_b_reg <= 4'h0;
    end
    else
    begin
      state_reg  <= state_next;
      running_reg <= running_next;
      index_reg  <= index_next;
      chan_a_reg <= chan_a_next;
      chan_b_reg <= chan_b_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // All outputs straight from flip-flops
  assign prdata                     = prdata_reg;
  assign pready                     = pready_reg;
  assign pslverr                    = pslverr_reg;
  assign cmd_rdata                  = cmd_rdata_reg;
  assign cmd_rvalid                 = cmd_rvalid_reg;
  assign active_entry               = index_reg;
  assign converter_a_channel_select = chan_a_reg;
  assign converter_b_channel_select = chan_b_reg;
  assign seq_running                = running_reg;

endmodule

// >>> shared/seq_stack_params.svh
// Constants for the sequencer stack entries and their register access
`ifndef SEQ_STACK_PARAMS_SVH
`define SEQ_STACK_PARAMS_SVH

// ------------------------------------------------------------
// Entry field layout
// ------------------------------------------------------------
`define SS_ENTRY_W      16
`define SS_DIR_BIT      15
`define SS_ADDR_HI      14
`define SS_ADDR_LO      9
`define SS_RET_BIT      8
`define SS_CHB_HI       7
`define SS_CHB_LO       4
`define SS_CHA_HI       3
`define SS_CHA_LO       0

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SS_STACK_BASE   6'h20
`define SS_IDX_E7       6'h27
`define SS_IDX_E10      6'h2a
`define SS_IDX_E11      6'h2b
`define SS_IDX_E12      6'h2c

// ------------------------------------------------------------
// Storage slots of the held entries
// ------------------------------------------------------------
`define SS_SLOT_E7      2'h0
`define SS_SLOT_E10     2'h1
`define SS_SLOT_E11     2'h2
`define SS_SLOT_E12     2'h3
`define SS_SLOTS        4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SS_RST_E7       16'h4f77
`define SS_RST_E10      16'h5400
`define SS_RST_E11      16'h5600
`define SS_RST_E12      16'h5800

// ------------------------------------------------------------
// Sequencer and bus constants
// ------------------------------------------------------------
`define SS_FIRST_ENTRY  4'h0
`define SS_INDEX_STEP   4'h1
`define SS_BYTE_LANE_OK 2'h0
`define SS_ZERO_HALF    16'h0000
`define SS_ZERO_WORD    32'h0000_0000

`endif

// >>> shared/seq_stack_pkg.sv
// Types shared by the sequencer stack design
package seq_stack_pkg;

  // Sequencer run state
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

  // One 16-bit stack entry
  typedef logic [15:0] entry_t;

endpackage

// >>> design/seq_stack_step.sv
// Next stack entry index for the channel sequencer
`include "seq_stack_params.svh"

module seq_stack_step
  import seq_stack_pkg::*;
(
  input  wire logic       start,
  input  wire logic       advance,
  input  wire logic       return_to_first,
  input  wire logic [3:0] cur_index,
  output logic      [3:0] next_index
);

  // ------------------------------------------------------------
  // Step selection
  // ------------------------------------------------------------

  // Start or return go to entry zero, an advance ascends by one, else hold
  always_comb
  begin
    if (start)
      next_index = `SS_FIRST_ENTRY;
    else if (advance && return_to_first)
      next_index = `SS_FIRST_ENTRY;
    else if (advance)
      next_index = cur_index + `SS_INDEX_STEP;
    else
      next_index = cur_index;
  end

endmodule

// >>> bench/seq_stack_checker.sv
// Port checks for the sequencer stack block
module seq_stack_checker
  import seq_stack_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic        cmd_rvalid,
  input wire logic        seq_start,
  input wire logic        conv_done,
  input wire logic [15:0] other_entry_word,
  input wire logic [3:0]  active_entry,
  input wire logic [3:0]  converter_a_channel_select,
  input wire logic [3:0]  converter_b_channel_select,
  input wire logic        seq_running
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic hit;
  logic held;
  logic step;
  // Command address match, entries held here, external step
  assign hit  = cmd_word[14:9] inside {6'h27, 6'h2a, 6'h2b, 6'h2c};
  assign held = active_entry inside {4'h7, 4'ha, 4'hb, 4'hc};
  assign step = conv_done && seq_running && !seq_start && !held;
  sequence s_cmd_read;
    cmd_valid && !cmd_word[15] && hit;
  endsequence
  sequence s_ret_step;
    step && other_entry_word[8];
  endsequence
  a_read_answer: assert property (s_cmd_read |=> cmd_rvalid)
    else $error("read command not answered");
  a_write_quiet: assert property (cmd_valid && cmd_word[15] |=> !cmd_rvalid)
    else $error("write command answered");
  a_miss_quiet: assert property (cmd_valid && !hit |=> !cmd_rvalid)
    else $error("foreign address answered");
  a_step_next: assert property (step && !other_entry_word[8] |=>
    active_entry == $past(active_entry) + 4'h1) else $error("no step to next");
  a_step_first: assert property (s_ret_step |=> active_entry == 4'h0)
    else $error("no return to first");
  a_start_first: assert property (seq_start |=> seq_running && active_entry == 4'h0)
    else $error("start not at first");
  a_idle_hold: assert property (!seq_running && !seq_start |=> active_entry == 4'h0)
    else $error("idle index moved");
  // Channel selects; the release edge still loads reset zeros
  a_chan_a: assert property (rst_n && !held |=>
    converter_a_channel_select == $past(other_entry_word[3:0])) else $error("chan a");
  a_chan_b: assert property (rst_n && !held |=>
    converter_b_channel_select == $past(other_entry_word[7:4])) else $error("chan b");
endmodule
bind sequencer_stack_entries_10_12 seq_stack_checker u_seq_stack_checker
(
  .mclk, .rst_n, .cmd_valid, .cmd_word, .cmd_rvalid, .seq_start, .conv_done,
  .other_entry_word, .active_entry, .converter_a_channel_select,
  .converter_b_channel_select, .seq_running
);

// >>> bench/conv_far_model.sv
// Far side: entries kept elsewhere and the converter
module conv_far_model
  import seq_stack_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [2:0]  dly,
  input  wire logic [3:0]  ret_idx,
  input  wire logic [3:0]  active_entry,
  output logic             conv_done,
  output entry_t           other_entry_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  // Own address, return bit on one index, channels from the index
  assign other_entry_word = {1'b0, 2'h2, active_entry, active_entry == ret_idx,
                             ~active_entry, active_entry};
  // Conversion ends dly cycles after go
  always @(posedge mclk)
  begin
    conv_done <= (cnt == 3'h1);
    cnt <= go ? dly : cnt - {2'h0, cnt != 3'h0};
  end
endmodule

// >>> bench/test_sequencer_stack_entries_10_12.sv
// Self-checking bench for the sequencer stack block
module test_sequencer_stack_entries_10_12
  import seq_stack_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, psel, penable, pwrite, cmd_valid, seq_start, go;
  logic        pready, pslverr, cmd_rvalid, conv_done, seq_running;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  entry_t      cmd_word, cmd_rdata, other_entry_word, r;
  logic [3:0]  active_entry, chan_a, chan_b, ret_idx;
  logic [2:0]  dly;
  logic [33:0] qa[$];
  entry_t      qc[$];
  logic [33:0] e;
  int          error_cnt = 0, tests_run = 0, i;
  logic [7:0]  ra[4] = '{8'h9c, 8'ha8, 8'hac, 8'hb0};
  entry_t      rv[4] = '{16'h4f77, 16'h5400, 16'h5600, 16'h5800};

  sequencer_stack_entries_10_12 u_sequencer_stack_entries_10_12
  (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_valid, .cmd_word, .cmd_rdata, .cmd_rvalid, .seq_start,
    .conv_done, .other_entry_word, .active_entry, .seq_running,
    .converter_a_channel_select(chan_a), .converter_b_channel_select(chan_b)
  );
  conv_far_model u_conv_far_model
  (
    .mclk, .go, .dly, .ret_idx, .active_entry, .conv_done, .other_entry_word
  );

  // -------
  // Helpers
  // -------
  function automatic entry_t lfsr(input entry_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d bad %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up;
    error_cnt++;
    $display("BAD %0t wait timed out", $time);
    finish_test();
  endtask
  // One bus transfer; result noted for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input entry_t x);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    qa.push_back({w, err, 16'h0, x});
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge mclk);
    while (!pready && ++n < 20);
    if (!pready)
      give_up();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input entry_t w, input logic rd, input entry_t x);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    if (rd)
      qc.push_back(x);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // One conversion, then the index it leads to
  task automatic step(input logic [3:0] ex);
    int n;
    @(posedge mclk);
    go <= 1'b1;
    dly <= ex[0] ? 3'h3 : 3'h1;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; n < 20 && !conv_done; n++)
      @(negedge mclk);
    if (!conv_done)
      give_up();
    @(negedge mclk);
    chk({28'h0, active_entry}, {28'h0, ex});
  endtask

  // Monitor: oldest note against each answer
  always @(negedge mclk)
  begin
    if (pready)
    begin
      e = qa.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33])
        chk(prdata, e[31:0]);
    end
    if (cmd_rvalid)
      chk({16'h0, cmd_rdata}, {16'h0, qc.pop_front()});
  end

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------
  // Scenarios
  // ----------
  initial
  begin
    {psel, penable, pwrite, cmd_valid, seq_start, go, rst_n} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    cmd_word = 16'h0;
    dly = 3'h1;
    ret_idx = 4'hf;
    r = 16'h0027;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (ra[k]) apb(1'b0, ra[k], 32'h0, 1'b0, rv[k]);
    $display("end reset values");
    apb(1'b0, 8'ha4, 32'h0, 1'b1, 16'h0);
    apb(1'b1, 8'ha9, 32'hffff_ffff, 1'b1, 16'h0);
    apb(1'b0, 8'ha8, 32'h0, 1'b0, 16'h5400);
    for (i = 1; i < 4; i++)
    begin
      r = lfsr(r);
      apb(1'b1, ra[i], {r, r}, 1'b0, 16'h0);
      apb(1'b0, ra[i], 32'h0, 1'b0, r);
    end
    cmd({1'b0, 6'h2c, 9'h0}, 1'b1, r);
    cmd({1'b1, 6'h2b, 9'h0a5}, 1'b0, 16'h0);
    cmd({1'b1, 6'h30, 9'h1ff}, 1'b0, 16'h0);
    cmd({1'b0, 6'h30, 9'h0}, 1'b0, 16'h0);
    apb(1'b0, 8'hac, 32'h0, 1'b0, {1'b1, 6'h2b, 9'h0a5});
    $display("end register access");
    seq_start <= 1'b1;
    @(posedge mclk);
    seq_start <= 1'b0;
    @(negedge mclk);
    chk({31'h0, seq_running}, 32'h1);
    for (i = 1; i < 9; i++) step(i < 8 ? i[3:0] : 4'h0);
    @(posedge mclk);
    apb(1'b1, 8'h9c, 32'h4e77, 1'b0, 16'h0);
    apb(1'b1, 8'ha8, 32'h55a5, 1'b0, 16'h0);
    for (i = 1; i < 11; i++) step(i[3:0]);
    @(negedge mclk);
    chk({24'h0, chan_b, chan_a}, 32'ha5);
    step(4'h0);
    @(posedge mclk);
    ret_idx <= 4'h2;
    for (i = 1; i < 4; i++) step(i < 3 ? i[3:0] : 4'h0);
    $display("end sequencer");
    repeat (3) @(posedge mclk);
    // Second reset in mid-run: entries written above must return to reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk({27'h0, seq_running, active_entry}, 32'h0);
    @(posedge mclk);
    foreach (ra[k]) apb(1'b0, ra[k], 32'h0, 1'b0, rv[k]);
    $display("end second reset");
    finish_test();
  end
endmodule
